// ==== hw/booklet_motor_fault_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "motor_monitor_defs.svh"
module booklet_motor_fault_monitor
  import motor_monitor_pkg::*;
#(
  parameter int PUSH_ON_MS  = `PUSH_ON_MS,
  parameter int PUSH_OFF_MS = `PUSH_OFF_MS,
  parameter int CLK_KHZ     = `CLK_KHZ,
  parameter int RATE_WIDTH  = 16
) (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic                  positioningPlateMotorDrive,
  input wire logic                  positioningPlateMotorPulse,
  input wire logic                  positioningPlateHomeSensor,
  input wire logic                  guidePlateMotorDrive,
  input wire logic                  guidePlateMotorPulse,
  input wire logic                  guideHomeSensor,
  input wire logic                  alignmentMotorDrive,
  input wire logic                  alignmentMotorPulse,
  input wire logic                  aligningPlateHomeSensor,
  input wire logic                  pushingPlateMotorDrive,
  input wire logic                  pushingPlateHomeSensor,
  input wire logic                  pushingPlateEdgeSensor,
  input wire logic                  pushingMotorClockSensor,
  input wire logic [RATE_WIDTH-1:0] pushExpectedPulses,
  input wire logic [31:0]           pushRateWindow,
  input wire logic                  frontDoorSwitch,
  input wire logic                  frontDoorSensor,
  output logic                      motionEnable,
  output logic [3:0]                faultCode,
  output logic                      anyFault
);
  localparam int ON_CYCLES  = PUSH_ON_MS * CLK_KHZ;
  localparam int OFF_CYCLES = PUSH_OFF_MS * CLK_KHZ;

  initial begin
    if (OFF_CYCLES < 1 || ON_CYCLES < OFF_CYCLES)
      $error("booklet_motor_fault_monitor: bad push times");
  end

  // Pin synchronisers: all sensors and pulse inputs come from outside
  localparam int NSYNC = 15;
  logic [NSYNC-1:0] syncA;
  logic [NSYNC-1:0] syncB;
  logic [NSYNC-1:0] pulseLast;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      syncA     <= '0;
      syncB     <= '0;
      pulseLast <= '0;
    end else begin
      syncA     <= {positioningPlateMotorDrive, positioningPlateMotorPulse,
                    positioningPlateHomeSensor, guidePlateMotorDrive,
                    guidePlateMotorPulse, guideHomeSensor,
                    alignmentMotorDrive, alignmentMotorPulse,
                    aligningPlateHomeSensor, pushingPlateMotorDrive,
                    pushingPlateHomeSensor, pushingPlateEdgeSensor,
                    pushingMotorClockSensor, frontDoorSwitch,
                    frontDoorSensor};
      syncB     <= syncA;
      pulseLast <= syncB;
    end
  end

  function automatic logic rise(input int idx);
    rise = syncB[idx] && !pulseLast[idx];
  endfunction

  logic posDrive, guideDrive, alignDrive, pushDrive, doorSwitch, doorSensor;
  assign posDrive   = syncB[14];
  assign guideDrive = syncB[11];
  assign alignDrive = syncB[8];
  assign pushDrive  = syncB[5];
  assign doorSwitch = syncB[1];
  assign doorSensor = syncB[0];

  assign motionEnable = doorSwitch && doorSensor;

  watch_if posW ();
  watch_if guideW ();
  watch_if alignW ();
  watch_if pushHomeW ();
  watch_if pushEdgeW ();

  // Pulse counting is gated by the door so an open door never runs limits
  assign posW.drive   = posDrive && motionEnable;
  assign posW.tick    = rise(13);
  assign posW.sensor  = syncB[12];
  assign guideW.drive = guideDrive && motionEnable;
  assign guideW.tick  = rise(10);
  assign guideW.sensor = syncB[9];
  assign alignW.drive  = alignDrive && motionEnable;
  assign alignW.tick   = rise(7);
  assign alignW.sensor = syncB[6];

  // Millisecond tick for the pushing motor timers
  localparam int MS_DIV = CLK_KHZ;
  logic [31:0] msCount;
  logic [31:0] next_msCount;
  logic        msTick;

  always_comb begin
    msTick       = (msCount == 32'(MS_DIV - 1));
    next_msCount = msTick ? 32'h0 : msCount + 32'h1;
    if (!pushDrive) next_msCount = 32'h0;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) msCount <= 32'h0;
    else       msCount <= next_msCount;
  end

  assign pushHomeW.drive  = pushDrive && motionEnable;
  assign pushHomeW.tick   = msTick;
  assign pushHomeW.sensor = syncB[4];
  assign pushEdgeW.drive  = pushDrive && motionEnable;
  assign pushEdgeW.tick   = msTick;
  assign pushEdgeW.sensor = syncB[3];

  sensor_watch #(
    .WIDTH     (16),
    .ON_LIMIT  (`POS_ON_PULSES),
    .OFF_LIMIT (`POS_OFF_PULSES)
  ) posWatch (
    .clk   (clk),
    .reset (reset),
    .w     (posW.mon)
  );

  sensor_watch #(
    .WIDTH     (16),
    .ON_LIMIT  (`GUIDE_ON_PULSES),
    .OFF_LIMIT (`GUIDE_OFF_PULSES)
  ) guideWatch (
    .clk   (clk),
    .reset (reset),
    .w     (guideW.mon)
  );

  sensor_watch #(
    .WIDTH     (16),
    .ON_LIMIT  (`ALIGN_ON_PULSES),
    .OFF_LIMIT (`ALIGN_OFF_PULSES)
  ) alignWatch (
    .clk   (clk),
    .reset (reset),
    .w     (alignW.mon)
  );

  sensor_watch #(
    .WIDTH     (16),
    .ON_LIMIT  (16'(PUSH_ON_MS)),
    .OFF_LIMIT (16'(PUSH_OFF_MS))
  ) pushHomeWatch (
    .clk   (clk),
    .reset (reset),
    .w     (pushHomeW.mon)
  );

  sensor_watch #(
    .WIDTH     (16),
    .ON_LIMIT  (16'(PUSH_ON_MS)),
    .OFF_LIMIT (16'(PUSH_OFF_MS))
  ) pushEdgeWatch (
    .clk   (clk),
    .reset (reset),
    .w     (pushEdgeW.mon)
  );

  // Rate window: clock-sensor pulses counted over pushRateWindow cycles
  logic [31:0] rateCount;
  logic [31:0] next_rateCount;
  logic        rateEnd;

  always_comb begin
    rateEnd        = (rateCount == pushRateWindow) && (pushRateWindow != 0);
    next_rateCount = rateEnd ? 32'h0 : rateCount + 32'h1;
    if (!pushDrive) next_rateCount = 32'h0;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) rateCount <= 32'h0;
    else       rateCount <= next_rateCount;
  end

  logic rateFault;

  pulse_rate_check #(
    .WIDTH (RATE_WIDTH)
  ) pushRate (
    .clk       (clk),
    .reset     (reset),
    .drive     (pushHomeW.drive),
    .pulse     (rise(2)),
    .windowEnd (rateEnd),
    .expected  (pushExpectedPulses),
    .fault     (rateFault)
  );

  logic [3:0] next_faultCode;
  always_comb begin
    next_faultCode = faultCode;
    next_faultCode[`CODE_POS]   = faultCode[`CODE_POS] | posW.fault;
    next_faultCode[`CODE_GUIDE] = faultCode[`CODE_GUIDE] | guideW.fault;
    next_faultCode[`CODE_ALIGN] = faultCode[`CODE_ALIGN] | alignW.fault;
    next_faultCode[`CODE_PUSH]  = faultCode[`CODE_PUSH] | pushHomeW.fault
                                  | pushEdgeW.fault | rateFault;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) faultCode <= 4'h0;
    else       faultCode <= next_faultCode;
  end

  assign anyFault = |faultCode;
endmodule
`default_nettype wire

// ==== include/motor_monitor_defs.svh ====
`ifndef MOTOR_MONITOR_DEFS_SVH
`define MOTOR_MONITOR_DEFS_SVH

// Drive-pulse limits per motor
`define POS_ON_PULSES     16'd1500
`define POS_OFF_PULSES    16'd300
`define GUIDE_ON_PULSES   16'd700
`define GUIDE_OFF_PULSES  16'd50
`define ALIGN_ON_PULSES   16'd500
`define ALIGN_OFF_PULSES  16'd50

// Pushing motor times
`define PUSH_ON_MS        300
`define PUSH_OFF_MS       80
`define CLK_KHZ           125000

// Fault code bit positions
`define CODE_POS          0
`define CODE_GUIDE        1
`define CODE_ALIGN        2
`define CODE_PUSH         3

`endif

// ==== include/motor_monitor_pkg.sv ====
package motor_monitor_pkg;
  typedef enum logic [1:0] {
    FAULT_POS,
    FAULT_GUIDE,
    FAULT_ALIGN,
    FAULT_PUSH
  } fault_code_t;

  typedef enum {
    IDLE,
    SEEK_OFF,
    SEEK_ON,
    DONE
  } watch_state_t;
endpackage

// ==== include/watch_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface watch_if;
  logic drive;
  logic tick;
  logic sensor;
  logic fault;
  modport ctrl (output drive, output tick, output sensor, input fault);
  modport mon  (input drive, input tick, input sensor, output fault);
endinterface
`default_nettype wire

// ==== hw/sensor_watch.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "motor_monitor_defs.svh"
module sensor_watch
  import motor_monitor_pkg::*;
#(
  parameter int              WIDTH     = 16,
  parameter logic [WIDTH-1:0] ON_LIMIT  = 16'h05dc,
  parameter logic [WIDTH-1:0] OFF_LIMIT = 16'h012c
) (
  input wire logic clk,
  input wire logic reset,
  watch_if.mon     w
);
  initial begin
    if (WIDTH < 2 || OFF_LIMIT == '0 || ON_LIMIT == '0)
      $error("sensor_watch: bad limits");
  end

  watch_state_t     state;
  watch_state_t     next_state;
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             fault;
  logic             next_fault;
  logic             driveLast;
  logic             next_driveLast;

  assign w.fault = fault;

  always_comb begin
    next_state     = state;
    next_count     = count;
    next_fault     = fault;
    next_driveLast = w.drive;
    unique case (state)
      IDLE: begin
        if (w.drive && !driveLast) begin
          next_count = '0;
          next_state = w.sensor ? SEEK_OFF : SEEK_ON;
        end
      end
      SEEK_OFF: begin
        if (!w.drive) begin
          next_state = IDLE;
        end else if (!w.sensor) begin
          next_state = SEEK_ON;
          next_count = '0;
        end else if (w.tick) begin
          next_count = count + 1'b1;
          if (count + 1'b1 >= OFF_LIMIT) begin
            next_fault = 1'b1;
            next_state = DONE;
          end
        end
      end
      SEEK_ON: begin
        if (!w.drive) begin
          next_state = IDLE;
        end else if (w.sensor) begin
          next_state = DONE;
        end else if (w.tick) begin
          next_count = count + 1'b1;
          if (count + 1'b1 >= ON_LIMIT) begin
            next_fault = 1'b1;
            next_state = DONE;
          end
        end
      end
      DONE: begin
        if (!w.drive) next_state = IDLE;
      end
    endcase
    if (fault) next_fault = 1'b1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state     <= IDLE;
      count     <= '0;
      fault     <= 1'b0;
      driveLast <= 1'b0;
    end else begin
      state     <= next_state;
      count     <= next_count;
      fault     <= next_fault;
      driveLast <= next_driveLast;
    end
  end
endmodule
`default_nettype wire

// ==== hw/pulse_rate_check.sv ====
`timescale 1ns/10ps
`default_nettype none
module pulse_rate_check #(
  parameter int WIDTH = 16
) (
  input wire logic             clk,
  input wire logic             reset,
  input wire logic             drive,
  input wire logic             pulse,
  input wire logic             windowEnd,
  input wire logic [WIDTH-1:0] expected,
  output logic                 fault
);
  initial begin
    if (WIDTH < 1) $error("pulse_rate_check: bad width");
  end

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             next_fault;

  always_comb begin
    next_count = count;
    next_fault = fault;
    if (!drive) begin
      next_count = '0;
    end else if (windowEnd) begin
      if (count < expected) next_fault = 1'b1;
      next_count = '0;
    end else if (pulse && count != '1) begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= '0;
      fault <= 1'b0;
    end else begin
      count <= next_count;
      fault <= next_fault;
    end
  end
endmodule
`default_nettype wire

// ==== sim/motor_sensor_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module motor_sensor_model (
  input wire logic        clk,
  input wire logic        drive,
  input wire logic        pulse,
  input wire logic        startOn,
  input wire logic [15:0] offAt,
  input wire logic [15:0] onAt,
  output logic            sensor
);
  logic [15:0] count;
  logic        lastPulse;

  initial begin
    sensor = 1'b0;
    count = 16'h0;
    lastPulse = 1'b0;
  end

  // Flag parks at its rest level while idle; moves only on real steps
  always @(posedge clk) begin
    lastPulse <= pulse;
    if (!drive) begin
      count <= 16'h0;
      sensor <= startOn;
    end else if (pulse && !lastPulse) begin
      count <= count + 16'h1;
      if (count + 16'h1 == offAt)
        sensor <= 1'b0;
      if (count + 16'h1 == onAt)
        sensor <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== sim/booklet_motor_fault_monitor_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module booklet_motor_fault_monitor_properties (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       guidePlateMotorDrive,
  input wire logic       guidePlateMotorPulse,
  input wire logic       guideHomeSensor,
  input wire logic       frontDoorSwitch,
  input wire logic       frontDoorSensor,
  input wire logic       motionEnable,
  input wire logic [3:0] faultCode,
  input wire logic       anyFault
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Raw pulse count runs ahead of the synced design count
  logic [15:0] guideCount, next_guideCount;
  logic        guideSeen, next_guideSeen, lastDrive, lastPulse;

  always_comb begin
    next_guideCount = guideCount;
    next_guideSeen = guideSeen | guideHomeSensor;
    if (guidePlateMotorDrive && !lastDrive) begin
      next_guideCount = 16'h0;
      next_guideSeen = guideHomeSensor;
    end else if (guidePlateMotorPulse && !lastPulse) begin
      next_guideCount = guideCount + 16'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      guideCount <= 16'h0;
      guideSeen <= 1'b0;
      lastDrive <= 1'b0;
      lastPulse <= 1'b0;
    end else begin
      guideCount <= next_guideCount;
      guideSeen <= next_guideSeen;
      lastDrive <= guidePlateMotorDrive;
      lastPulse <= guidePlateMotorPulse;
    end
  end

  property p_sticky;
    (faultCode & $past(faultCode)) == $past(faultCode);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("fault bit dropped without reset");
  property p_any;
    anyFault == (|faultCode);
  endproperty
  a_any: assert property (p_any)
    else $error("summary flag differs from fault bits");
  property p_switch_open;
    (!frontDoorSwitch)[*3] |-> !motionEnable;
  endproperty
  a_switch_open: assert property (p_switch_open)
    else $error("motion allowed with switch open");
  property p_sensor_open;
    (!frontDoorSensor)[*3] |-> !motionEnable;
  endproperty
  a_sensor_open: assert property (p_sensor_open)
    else $error("motion allowed with sensor open");
  property p_closed;
    (frontDoorSwitch && frontDoorSensor)[*3] |-> motionEnable;
  endproperty
  a_closed: assert property (p_closed)
    else $error("motion blocked with door closed");
  property p_guide_idle;
    (!guidePlateMotorDrive)[*8] |=> !$rose(faultCode[1]);
  endproperty
  a_guide_idle: assert property (p_guide_idle)
    else $error("guide fault without drive");
  property p_guide_early;
    $rose(faultCode[1]) |-> guideCount >= 16'd50;
  endproperty
  a_guide_early: assert property (p_guide_early)
    else $error("guide fault before off limit");
  property p_guide_late;
    $rose(guideCount == 16'd700) && !guideSeen && motionEnable
      |-> ##[1:12] faultCode[1];
  endproperty
  a_guide_late: assert property (p_guide_late)
    else $error("guide fault missing after on limit");

  c_guide: cover property ($rose(faultCode[1]));
  c_push: cover property ($rose(faultCode[3]));
  c_door: cover property ($fell(motionEnable));
endmodule

bind booklet_motor_fault_monitor booklet_motor_fault_monitor_properties
  u_props (.clk, .reset, .guidePlateMotorDrive, .guidePlateMotorPulse,
  .guideHomeSensor, .frontDoorSwitch, .frontDoorSensor, .motionEnable,
  .faultCode, .anyFault);
`default_nettype wire

// ==== sim/booklet_motor_fault_monitor_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module booklet_motor_fault_monitor_tb_top;
  localparam int NEVER = 65535;
  localparam int KHZ = 2;
  localparam int ON_LIM [3] = '{1500, 700, 500};
  localparam int OFF_LIM [3] = '{300, 50, 50};
  logic        clk, reset, doorSw, doorSen, motionEnable, anyFault;
  logic        pushDrive, pushHome, pushEdge, pushClk, f;
  logic [2:0]  drive, pulse, startOn, sensor;
  logic [15:0] offAt [3], onAt [3], pushExp;
  logic [3:0]  faultCode;
  int          num_errors, num_checks, cycles;

  booklet_motor_fault_monitor #(.CLK_KHZ(KHZ)) u_booklet_motor_fault_monitor (
    .clk, .reset, .positioningPlateMotorDrive(drive[0]),
    .positioningPlateMotorPulse(pulse[0]),
    .positioningPlateHomeSensor(sensor[0]),
    .guidePlateMotorDrive(drive[1]), .guidePlateMotorPulse(pulse[1]),
    .guideHomeSensor(sensor[1]), .alignmentMotorDrive(drive[2]),
    .alignmentMotorPulse(pulse[2]), .aligningPlateHomeSensor(sensor[2]),
    .pushingPlateMotorDrive(pushDrive), .pushingPlateHomeSensor(pushHome),
    .pushingPlateEdgeSensor(pushEdge), .pushingMotorClockSensor(pushClk),
    .pushExpectedPulses(pushExp), .pushRateWindow(32'd100),
    .frontDoorSwitch(doorSw), .frontDoorSensor(doorSen),
    .motionEnable, .faultCode, .anyFault);

  for (genvar i = 0; i < 3; i++) begin : g_motor
    motor_sensor_model u_motor_sensor_model (.clk, .drive(drive[i]),
      .pulse(pulse[i]), .startOn(startOn[i]), .offAt(offAt[i]),
      .onAt(onAt[i]), .sensor(sensor[i]));
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      results();
    end
  end

  task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic power_cycle();
    reset = 1'b1;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    check("faults after reset", faultCode, 4'h0); // cleared by reset
  endtask

  task automatic run_motor(int m, bit on, int offP, int onP, int n);
    startOn[m] = on;
    offAt[m] = 16'(offP);
    onAt[m] = 16'(onP);
    repeat (2) @(negedge clk);
    drive[m] = 1'b1;
    repeat (4) @(negedge clk);
    repeat (2 * n) begin
      pulse[m] = ~pulse[m];
      repeat (2) @(negedge clk);
    end
    repeat (12) @(negedge clk);
    drive[m] = 1'b0;
    @(negedge clk);
  endtask

  function automatic bit predict(bit on, int offP, int onP, int offL,
                                 int onL, int n);
    if (on && offP > offL)
      return n >= offL;
    if (on)
      return onP - offP > onL && n - offP >= onL;
    return onP > onL && n >= onL;
  endfunction

  task automatic run_push(int k, output logic fault);
    int t [4];
    t = '{50, 400, 50, 400};
    if (k >= 1 && k <= 4)
      t[k - 1] = NEVER;
    pushExp = (k == 5) ? 16'd60 : 16'd10;
    fault = t[0] > 80 * KHZ || t[2] > 80 * KHZ || t[1] - t[0] > 300 * KHZ
      || t[3] - t[2] > 300 * KHZ || 100 / 4 < pushExp;
    pushHome = 1'b1;
    pushEdge = 1'b1;
    pushDrive = 1'b1;
    for (int i = 0; i < 900; i++) begin
      @(negedge clk);
      pushClk = i[1];
      if (i == t[0]) pushHome = 1'b0;
      if (i == t[1]) pushHome = 1'b1;
      if (i == t[2]) pushEdge = 1'b0;
      if (i == t[3]) pushEdge = 1'b1;
    end
    pushDrive = 1'b0;
  endtask

  initial begin
    int offP, onP, n, mg;
    reset = 1'b1;
    {drive, pulse, startOn} = 9'h0;
    {doorSw, doorSen, pushHome, pushEdge} = 4'hf;
    {pushDrive, pushClk} = 2'h0;
    pushExp = 16'd10;
    offAt = '{default: 16'hffff};
    onAt = '{default: 16'hffff};
    mg = $urandom(32'hb067);
    // second short run proves the count restarts
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 4; k++) begin
        mg = 2 + $urandom % 8;
        offP = (k == 2) ? OFF_LIM[m] - mg : NEVER;
        onP = (k == 2) ? offP + ON_LIM[m] - mg : NEVER;
        case (k)
          0: n = OFF_LIM[m] + mg;
          1: n = ON_LIM[m] + mg;
          2: n = ON_LIM[m] + OFF_LIM[m];
          default: n = OFF_LIM[m] - mg;
        endcase
        power_cycle();
        run_motor(m, k != 1, offP, onP, n);
        if (k == 3)
          run_motor(m, 1'b1, offP, onP, n);
        f = predict(k != 1, offP, onP, OFF_LIM[m], ON_LIM[m], n);
        check("motor fault", faultCode, f ? 4'(1 << m) : 4'h0); // 6
      end
    end
    power_cycle();
    doorSw = 1'b0;
    run_motor(1, 1'b1, NEVER, NEVER, 60);
    check("open motion", {3'h0, motionEnable}, 4'h0); // switch open
    check("open fault", faultCode, 4'h0); // watch idle
    {doorSw, doorSen} = 2'b10;
    repeat (4) @(negedge clk);
    check("sensor motion", {3'h0, motionEnable}, 4'h0); // sensor open
    doorSen = 1'b1;
    repeat (4) @(negedge clk);
    check("closed motion", {3'h0, motionEnable}, 4'h1); // both closed
    for (int k = 0; k < 6; k++) begin
      power_cycle();
      run_push(k, f);
      check("push fault", faultCode, f ? 4'h8 : 4'h0); // 11 push bit
    end
    results();
  end
endmodule
`default_nettype wire
